// [dmps_pkg.sv]
// constants, modes and pin roles of the debug mode pin select block
package dmps_pkg;

	// ==========================================================
	// port group geometry and synchroniser depth
	localparam int unsigned PORT_W      = 7;
	localparam int unsigned SYNC_STAGES = 2;

	// ==========================================================
	// operation modes decoded from the four straps
	typedef enum logic [1:0] {
		OPM_NORMAL = 2'h0,
		OPM_FLASH  = 2'h1,
		OPM_BSCAN  = 2'h3,
		OPM_UNDEF  = 2'h2
	} dmps_opmode_e;

	// debug interface requests and assignments
	typedef enum logic [1:0] {
		DBG_NONE      = 2'h0,
		DBG_ONE_LINE  = 2'h1,
		DBG_FOUR_LINE = 2'h2,
		DBG_NEXUS     = 2'h3
	} dmps_dbgmode_e;

	// strap lock state machine
	typedef enum logic {
		ST_HOLD   = 1'b0,
		ST_LOCKED = 1'b1
	} dmps_lock_e;

	// ==========================================================
	// strap levels that select a mode
	localparam logic FLASH_PRI_NORMAL = 1'b0;
	localparam logic FLASH_SEC_PROG   = 1'b0;
	localparam logic GEN_A_BSCAN      = 1'b0;
	localparam logic GEN_B_BSCAN      = 1'b1;

	// ==========================================================
	// bit positions inside the debug port group
	localparam int unsigned PIN_LP_BIDIR  = 0;
	localparam int unsigned PIN_LP_DIN    = 0;
	localparam int unsigned PIN_LP_DOUT   = 1;
	localparam int unsigned PIN_LP_CLKOUT = 5;
	localparam int unsigned PIN_NX_TDI    = 0;
	localparam int unsigned PIN_NX_TDO    = 1;
	localparam int unsigned PIN_NX_TMS    = 3;
	localparam int unsigned PIN_NX_TRST   = 4;
	localparam int unsigned PIN_NX_RDY    = 5;
	localparam int unsigned PIN_NX_EVT    = 6;

	// ==========================================================
	// pins owned by debug, pins it drives, pins it drives on demand
	localparam logic [6:0] OWN_NONE  = 7'h00;
	localparam logic [6:0] OWN_ONE   = 7'h01;
	localparam logic [6:0] OWN_FOUR  = 7'h27;
	localparam logic [6:0] OWN_NEXUS = 7'h7f;
	localparam logic [6:0] DRV_NONE  = 7'h00;
	localparam logic [6:0] DRV_FOUR  = 7'h22;
	localparam logic [6:0] DRV_NEXUS = 7'h62;
	localparam logic [6:0] BIDIR_ONE = 7'h01;

	// ==========================================================
	// values after reset
	localparam dmps_opmode_e  OPM_RESET = OPM_NORMAL;
	localparam dmps_dbgmode_e DBG_RESET = DBG_NONE;
	localparam logic [6:0]    PORT_RESET = 7'h00;

endpackage : dmps_pkg

// [dmps_sync.sv]
// multi-bit two-flop level synchroniser without reset
`timescale 1ns/1ps
module dmps_sync #(
	parameter int unsigned WIDTH  = 1,
	parameter int unsigned STAGES = dmps_pkg::SYNC_STAGES
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	import dmps_pkg::*;

	logic [WIDTH-1:0] stage_q [STAGES];
	logic [WIDTH-1:0] stage_d [STAGES];

	// refuse a chain too short to settle metastability
	if (STAGES < 2) begin : g_bad_stages
		$error("dmps_sync needs at least two stages");
	end

	// shift chain, first stage only feeds the second
	always_comb begin
		stage_d[0] = d;
		for (int i = 1; i < STAGES; i++) begin
			stage_d[i] = stage_q[i-1];
		end
	end

	// register the chain
	always_ff @(posedge clk) begin
		stage_q <= stage_d;
	end

	assign q = stage_q[STAGES-1];

endmodule : dmps_sync

// [dmps_pin_cell.sv]
// one pin of the debug port group: debug or general-purpose ownership
`timescale 1ns/1ps
module dmps_pin_cell (
	input  wire logic enable,
	input  wire logic own,
	input  wire logic dbg_out,
	input  wire logic dbg_oe,
	input  wire logic gpio_out,
	input  wire logic gpio_oe,
	output logic      pad_out,
	output logic      pad_oe
);
	import dmps_pkg::*;

	// pins stay undriven until the straps are locked
	always_comb begin
		pad_out = 1'b0;
		pad_oe  = 1'b0;
		if (enable) begin
			pad_out = own ? dbg_out : gpio_out;
			pad_oe  = own ? dbg_oe  : gpio_oe;
		end
	end

endmodule : dmps_pin_cell

// [dmps_top.sv]
// mode strap decode and debug port group pin assignment
//
// Operation
// - primary flash strap low gives normal operation
// - primary high, secondary low gives flash programming
// - both high, a low, b high: boundary scan
// - one-line debug: bit 0 bidir, others general
// - four-line debug: bits 0,1,2,5 debug, others general
// - nexus debug: all seven bits debug signals
`timescale 1ns/1ps
module dmps_top #(
	parameter int unsigned WIDTH = dmps_pkg::PORT_W
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     link_clk,
	input  wire logic                     flash_strap_primary,
	input  wire logic                     flash_strap_secondary,
	input  wire logic                     general_strap_a,
	input  wire logic                     general_strap_b,
	input  wire dmps_pkg::dmps_dbgmode_e  debug_if_req,
	input  wire logic [WIDTH-1:0]         pad_in,
	output logic      [WIDTH-1:0]         pad_out,
	output logic      [WIDTH-1:0]         pad_oe,
	input  wire logic [WIDTH-1:0]         gpio_out,
	input  wire logic [WIDTH-1:0]         gpio_oe,
	output logic      [WIDTH-1:0]         gpio_in,
	output logic      [WIDTH-1:0]         port_debug_owned,
	output dmps_pkg::dmps_opmode_e        op_mode,
	output dmps_pkg::dmps_dbgmode_e       debug_mode,
	output logic                          mode_locked,
	output logic                          mode_normal,
	output logic                          mode_flash,
	output logic                          mode_bscan,
	input  wire logic                     lowpin_bidir_data_out,
	input  wire logic                     lowpin_bidir_data_oe,
	input  wire logic                     lowpin_data_out,
	input  wire logic                     lowpin_clock_out,
	input  wire logic                     nexus_test_data_out,
	input  wire logic                     nexus_ready_out,
	input  wire logic                     event_output,
	output logic                          lowpin_bidir_data_in,
	output logic                          lowpin_data_in,
	output logic                          nexus_test_data_in,
	output logic                          nexus_test_mode_select,
	output logic                          nexus_test_reset,
	output dmps_pkg::dmps_dbgmode_e       link_debug_mode
);
	import dmps_pkg::*;

	// the pin role masks are fixed at seven bits
	if (WIDTH != PORT_W) begin : g_bad_width
		$error("dmps_top supports only the seven-bit port group");
	end

	// ==========================================================
	// synchronisers into the main clock domain
	logic [3:0]       strap_raw;
	logic [3:0]       strap_s;
	logic [WIDTH-1:0] pad_s;

	assign strap_raw = {general_strap_b, general_strap_a,
	                    flash_strap_secondary, flash_strap_primary};

	// strap pins settle through two flops before the decoder
	dmps_sync #(
		.WIDTH  (4),
		.STAGES (SYNC_STAGES)
	) u_strap_sync (
		.clk (clk),
		.d   (strap_raw),
		.q   (strap_s)
	);

	// pad levels for general-purpose reads
	dmps_sync #(
		.WIDTH  (WIDTH),
		.STAGES (SYNC_STAGES)
	) u_pad_sync (
		.clk (clk),
		.d   (pad_in),
		.q   (pad_s)
	);

	// ==========================================================
	// strap decoder
	function automatic dmps_opmode_e decode_mode(input logic [3:0] s);
		dmps_opmode_e m;
		if (s[0] == FLASH_PRI_NORMAL) begin
			m = OPM_NORMAL;
		end else if (s[1] == FLASH_SEC_PROG) begin
			m = OPM_FLASH;
		end else if (s[2] == GEN_A_BSCAN && s[3] == GEN_B_BSCAN) begin
			m = OPM_BSCAN;
		end else begin
			m = OPM_UNDEF;
		end
		return m;
	endfunction : decode_mode

	// ==========================================================
	// lock state machine in the main domain
	dmps_lock_e    state_q;
	dmps_lock_e    state_d;
	dmps_opmode_e  mode_q;
	dmps_opmode_e  mode_d;
	dmps_dbgmode_e dbg_q;
	dmps_dbgmode_e dbg_d;

	// capture on the first edge after release, then hold
	always_comb begin
		state_d = state_q;
		mode_d  = mode_q;
		dbg_d   = dbg_q;
		if (!nrst) begin
			state_d = ST_HOLD;
			mode_d  = OPM_RESET;
			dbg_d   = DBG_RESET;
		end else begin
			unique case (state_q)
				ST_HOLD: begin
					state_d = ST_LOCKED;
					mode_d  = decode_mode(strap_s);
					// debug port only serves normal operation
					dbg_d   = (decode_mode(strap_s) == OPM_NORMAL) ?
					          debug_if_req : DBG_NONE;
				end
				ST_LOCKED: begin
					state_d = ST_LOCKED;
				end
			endcase
		end
	end

	// register lock state
	always_ff @(posedge clk) begin
		state_q <= state_d;
		mode_q  <= mode_d;
		dbg_q   <= dbg_d;
	end

	assign mode_locked = (state_q == ST_LOCKED);
	assign op_mode     = mode_q;
	assign debug_mode  = dbg_q;
	assign mode_normal = mode_locked && (mode_q == OPM_NORMAL);
	assign mode_flash  = mode_locked && (mode_q == OPM_FLASH);
	assign mode_bscan  = mode_locked && (mode_q == OPM_BSCAN);

	// ==========================================================
	// pin role masks for the locked debug assignment
	logic [WIDTH-1:0] own_m;
	logic [WIDTH-1:0] drv_m;
	logic [WIDTH-1:0] bidir_m;

	// ownership map per debug interface
	always_comb begin
		own_m   = OWN_NONE;
		drv_m   = DRV_NONE;
		bidir_m = OWN_NONE;
		unique case (dbg_q)
			DBG_NONE: begin
				own_m = OWN_NONE;
			end
			DBG_ONE_LINE: begin
				own_m   = OWN_ONE;
				bidir_m = BIDIR_ONE;
			end
			DBG_FOUR_LINE: begin
				own_m = OWN_FOUR;
				drv_m = DRV_FOUR;
			end
			DBG_NEXUS: begin
				own_m = OWN_NEXUS;
				drv_m = DRV_NEXUS;
			end
		endcase
	end

	assign port_debug_owned = mode_locked ? own_m : PORT_RESET;

	// ==========================================================
	// general-purpose read-back, debug-owned pins read as zero
	logic [WIDTH-1:0] gpio_in_q;
	logic [WIDTH-1:0] gpio_in_d;

	// next read-back value
	always_comb begin
		gpio_in_d = PORT_RESET;
		if (nrst && mode_locked) begin
			gpio_in_d = pad_s & ~own_m;
		end
	end

	// register read-back
	always_ff @(posedge clk) begin
		gpio_in_q <= gpio_in_d;
	end

	assign gpio_in = gpio_in_q;

	// ==========================================================
	// crossing into the link clock domain
	logic       link_nrst;
	logic       link_lock_s;
	logic [WIDTH-1:0] link_pad_s;

	// reset level seen by link logic
	dmps_sync #(
		.WIDTH  (1),
		.STAGES (SYNC_STAGES)
	) u_link_rst_sync (
		.clk (link_clk),
		.d   (nrst),
		.q   (link_nrst)
	);

	// lock level; assignment bus is static once it is seen high
	dmps_sync #(
		.WIDTH  (1),
		.STAGES (SYNC_STAGES)
	) u_link_lock_sync (
		.clk (link_clk),
		.d   (mode_locked),
		.q   (link_lock_s)
	);

	// debug input pins on the link clock
	dmps_sync #(
		.WIDTH  (WIDTH),
		.STAGES (SYNC_STAGES)
	) u_link_pad_sync (
		.clk (link_clk),
		.d   (pad_in),
		.q   (link_pad_s)
	);

	// ==========================================================
	// link domain: assignment copy, debug pad data, debug inputs
	dmps_dbgmode_e    lmode_q;
	dmps_dbgmode_e    lmode_d;
	logic [WIDTH-1:0] dout_q;
	logic [WIDTH-1:0] dout_d;
	logic             doe_q;
	logic             doe_d;
	logic [4:0]       din_q;
	logic [4:0]       din_d;

	// next values on the link clock
	always_comb begin
		lmode_d = lmode_q;
		dout_d  = PORT_RESET;
		doe_d   = 1'b0;
		din_d   = 5'h00;
		if (!link_nrst || !link_lock_s) begin
			lmode_d = DBG_RESET;
		end else begin
			lmode_d = dbg_q; // quasi-static after lock
			unique case (lmode_q)
				DBG_NONE: begin
					doe_d = 1'b0;
				end
				DBG_ONE_LINE: begin
					dout_d[PIN_LP_BIDIR] = lowpin_bidir_data_out;
					doe_d    = lowpin_bidir_data_oe;
					din_d[0] = link_pad_s[PIN_LP_BIDIR];
				end
				DBG_FOUR_LINE: begin
					dout_d[PIN_LP_DOUT]   = lowpin_data_out;
					dout_d[PIN_LP_CLKOUT] = lowpin_clock_out;
					din_d[1] = link_pad_s[PIN_LP_DIN];
				end
				DBG_NEXUS: begin
					dout_d[PIN_NX_TDO] = nexus_test_data_out;
					dout_d[PIN_NX_RDY] = nexus_ready_out;
					dout_d[PIN_NX_EVT] = event_output;
					din_d[2] = link_pad_s[PIN_NX_TDI];
					din_d[3] = link_pad_s[PIN_NX_TMS];
					din_d[4] = link_pad_s[PIN_NX_TRST];
				end
			endcase
		end
	end

	// register link domain state
	always_ff @(posedge link_clk) begin
		lmode_q <= lmode_d;
		dout_q  <= dout_d;
		doe_q   <= doe_d;
		din_q   <= din_d;
	end

	assign link_debug_mode        = lmode_q;
	assign lowpin_bidir_data_in   = din_q[0];
	assign lowpin_data_in         = din_q[1];
	assign nexus_test_data_in     = din_q[2];
	assign nexus_test_mode_select = din_q[3];
	assign nexus_test_reset       = din_q[4];

	// ==========================================================
	// pad multiplexers, one cell per pin
	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		dmps_pin_cell u_cell (
			.enable   (mode_locked),
			.own      (own_m[i]),
			.dbg_out  (dout_q[i]),
			.dbg_oe   (drv_m[i] | (bidir_m[i] & doe_q)),
			.gpio_out (gpio_out[i]),
			.gpio_oe  (gpio_oe[i]),
			.pad_out  (pad_out[i]),
			.pad_oe   (pad_oe[i])
		);
	end

endmodule : dmps_top

// [dmps_props.sv]
// assertions on strap decode, lock and pin ownership
`timescale 1ns/1ps
module dmps_chk #(
	parameter int unsigned WIDTH = 7
) (
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic                    flash_strap_primary,
	input wire logic                    flash_strap_secondary,
	input wire logic                    general_strap_a,
	input wire logic                    general_strap_b,
	input wire logic [WIDTH-1:0]        gpio_oe,
	input wire logic [WIDTH-1:0]        pad_oe,
	input wire logic [WIDTH-1:0]        port_debug_owned,
	input wire dmps_pkg::dmps_opmode_e  op_mode,
	input wire dmps_pkg::dmps_dbgmode_e debug_mode,
	input wire logic                    mode_locked,
	input wire logic                    mode_normal,
	input wire logic                    mode_flash,
	input wire logic                    mode_bscan
);
	import dmps_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// decode at capture, straps seen three edges back
	AST_NORMAL: assert property ($rose(mode_locked)
		&& !$past(flash_strap_primary, 3) |-> mode_normal)
		else $error("normal mode missed");
	AST_FLASH: assert property ($rose(mode_locked)
		&& $past(flash_strap_primary, 3)
		&& !$past(flash_strap_secondary, 3)
		|-> mode_flash && debug_mode == DBG_NONE)
		else $error("flash mode missed");
	AST_BSCAN: assert property ($rose(mode_locked)
		&& $past(flash_strap_primary, 3)
		&& $past(flash_strap_secondary, 3)
		&& !$past(general_strap_a, 3)
		&& $past(general_strap_b, 3) |-> mode_bscan)
		else $error("boundary scan missed");
	// ==========================================================
	// lock and pin ownership
	AST_HOLD: assert property (mode_locked |=> mode_locked
		&& $stable(op_mode) && $stable(debug_mode))
		else $error("mode changed while locked");
	AST_PRELOCK: assert property (!mode_locked |-> pad_oe == '0)
		else $error("pad driven before lock");
	AST_OWN_ONE: assert property (mode_locked
		&& debug_mode == DBG_ONE_LINE |-> port_debug_owned == OWN_ONE)
		else $error("one-line ownership wrong");
	AST_OWN_FOUR: assert property (mode_locked
		&& debug_mode == DBG_FOUR_LINE |-> port_debug_owned == OWN_FOUR)
		else $error("four-line ownership wrong");
	AST_OWN_NEXUS: assert property (mode_locked
		&& debug_mode == DBG_NEXUS |-> port_debug_owned == OWN_NEXUS
		&& (pad_oe & 7'h1d) == 7'h00)
		else $error("nexus ownership wrong");
	AST_GPIO: assert property (mode_locked
		&& !port_debug_owned[3] |-> pad_oe[3] == gpio_oe[3])
		else $error("general pin enable lost");
	C_NEXUS: cover property ($rose(mode_locked) && debug_mode == DBG_NEXUS);
	C_FOUR: cover property ($rose(mode_locked) && debug_mode == DBG_FOUR_LINE);
	C_FLASH: cover property ($rose(mode_locked) && mode_flash);
endmodule : dmps_chk

// [dmps_emu.sv]
// emulator model: strap levels and pad drive of the debug tool
`timescale 1ns/1ps
module dmps_emu #(
	parameter int unsigned WIDTH = 7
) (
	input  wire logic [3:0]       strap_set,
	input  wire logic [WIDTH-1:0] pin_val,
	input  wire logic [WIDTH-1:0] pad_out,
	input  wire logic [WIDTH-1:0] pad_oe,
	output logic                  flash_strap_primary,
	output logic                  flash_strap_secondary,
	output logic                  general_strap_a,
	output logic                  general_strap_b,
	output logic      [WIDTH-1:0] pad_in
);
	// ==========================================================
	// straps held steady by the tool across reset release
	assign flash_strap_primary   = strap_set[3];
	assign flash_strap_secondary = strap_set[2];
	assign general_strap_a       = strap_set[1];
	assign general_strap_b       = strap_set[0];
	// device drive wins where enabled, else the tool drives
	assign pad_in = (pad_out & pad_oe) | (pin_val & ~pad_oe);
endmodule : dmps_emu

// [test_debug_mode_pin_select.sv]
// testbench for the debug mode pin select block
`timescale 1ns/1ps
module test_debug_mode_pin_select;
	import dmps_pkg::*;
	logic clk, nrst, link_clk, fp, fs, ga, gb, locked, mn, mf, mb;
	logic [3:0] strap_set;
	logic [6:0] core;
	logic [6:0] pin_val, gpio_out, gpio_oe, pad_in, pad_out, pad_oe;
	logic [6:0] gpio_in, owned;
	logic bd_in, ld_in, nx_di, nx_ms, nx_rs;
	dmps_dbgmode_e req, debug_mode, ldm;
	dmps_opmode_e op_mode;
	int bad_count, total_checks;
	dmps_top i_dut (.clk(clk), .nrst(nrst), .link_clk(link_clk),
		.flash_strap_primary(fp), .flash_strap_secondary(fs),
		.general_strap_a(ga), .general_strap_b(gb), .debug_if_req(req),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
		.port_debug_owned(owned), .op_mode(op_mode),
		.debug_mode(debug_mode), .mode_locked(locked),
		.mode_normal(mn), .mode_flash(mf), .mode_bscan(mb),
		.lowpin_bidir_data_out(core[0]), .lowpin_bidir_data_oe(core[1]),
		.lowpin_data_out(core[2]), .lowpin_clock_out(core[3]),
		.nexus_test_data_out(core[4]), .nexus_ready_out(core[5]),
		.event_output(core[6]), .lowpin_bidir_data_in(bd_in),
		.lowpin_data_in(ld_in), .nexus_test_data_in(nx_di),
		.nexus_test_mode_select(nx_ms), .nexus_test_reset(nx_rs),
		.link_debug_mode(ldm));
	dmps_emu i_emu (.strap_set(strap_set), .pin_val(pin_val),
		.pad_out(pad_out), .pad_oe(pad_oe), .flash_strap_primary(fp),
		.flash_strap_secondary(fs), .general_strap_a(ga),
		.general_strap_b(gb), .pad_in(pad_in));
	// ==========================================================
	// clocks: link clock offset so the two never line up
	always #2.5 clk = ~clk;
	initial begin
		link_clk = 1'b0;
		#1.1;
		forever #7.5 link_clk = ~link_clk;
	end
	// ==========================================================
	// helpers
	task chk(input logic [6:0] got, input logic [6:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task rst_to(input logic [3:0] s, input dmps_dbgmode_e r);
		nrst = 1'b0;
		strap_set = s;
		req = r;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (30) @(negedge clk);
	endtask : rst_to
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	// ==========================================================
	// scenarios
	task sc_modes;
		rst_to(4'h7, DBG_NONE);
		chk(mn, 1'b1);
		chk(locked, 1'b1);
		rst_to(4'ha, DBG_NEXUS);
		chk(op_mode, OPM_FLASH);
		chk(mf, 1'b1);
		chk(debug_mode, DBG_NONE);
		chk(ldm, DBG_NONE);
		rst_to(4'hd, DBG_NONE);
		chk(mb, 1'b1);
		rst_to(4'hf, DBG_NONE);
		chk(mb, 1'b0);
		chk(op_mode, OPM_UNDEF);
	endtask : sc_modes
	task sc_one;
		gpio_oe = 7'h7f;
		gpio_out = 7'h55;
		core = 7'h03;
		rst_to(4'h0, DBG_ONE_LINE);
		chk(owned, OWN_ONE);
		chk(pad_oe, 7'h7f);
		chk(pad_out, 7'h55);
		core = 7'h00;
		pin_val = 7'h01;
		repeat (20) @(negedge clk);
		chk(pad_oe, 7'h7e);
		chk(bd_in, 1'b1);
		chk(gpio_in, 7'h54);
	endtask : sc_one
	task sc_four;
		gpio_out = 7'h00;
		// general enables also asked on owned input pins 0 and 2
		gpio_oe = 7'h4d;
		core = 7'h0c;
		pin_val = 7'h01;
		rst_to(4'h0, DBG_FOUR_LINE);
		chk(owned, OWN_FOUR);
		chk(pad_oe, 7'h6a);
		chk(pad_out & pad_oe, 7'h22);
		chk(ld_in, 1'b1);
	endtask : sc_four
	task sc_nexus;
		gpio_out = 7'h7f;
		core = 7'h70;
		pin_val = 7'h19;
		rst_to(4'h0, DBG_NEXUS);
		chk(owned, OWN_NEXUS);
		chk(ldm, DBG_NEXUS);
		chk(pad_oe, 7'h62);
		chk(pad_out & pad_oe, 7'h62);
		chk({nx_di, nx_ms, nx_rs}, 7'h07);
		chk(gpio_in, 7'h00);
		strap_set = 4'ha;
		req = DBG_NONE;
		repeat (10) @(negedge clk);
		chk(op_mode, OPM_NORMAL);
		chk(debug_mode, DBG_NEXUS);
		chk(locked, 1'b1);
	endtask : sc_nexus
	// ==========================================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		strap_set = 4'h0;
		pin_val = 7'h00;
		req = DBG_NONE;
		gpio_out = 7'h00;
		gpio_oe = 7'h00;
		core = 7'h00;
		bad_count = 0;
		total_checks = 0;
		@(negedge clk);
		sc_modes();
		sc_one();
		sc_four();
		sc_nexus();
		print_verdict();
	end
	// several times the expected run length
	initial begin
		#20000;
		bad_count++;
		print_verdict();
	end
endmodule : test_debug_mode_pin_select
bind dmps_top dmps_chk #(.WIDTH(WIDTH)) i_chk (.clk, .nrst,
	.flash_strap_primary, .flash_strap_secondary, .general_strap_a,
	.general_strap_b, .gpio_oe, .pad_oe, .port_debug_owned, .op_mode,
	.debug_mode, .mode_locked, .mode_normal, .mode_flash, .mode_bscan);
